//--- pkg/vcr_defines.vh
// constants of the capability register bank: indices, field layout, masks
// assumes inclusion by bare name from rtl files only
`ifndef VCR_DEFINES_VH
`define VCR_DEFINES_VH

// ****************************************
// register indices
// ****************************************
`define VCR_IDX_CR0_MB1 32'h0000_0486
`define VCR_IDX_CR0_MAY1 32'h0000_0487
`define VCR_IDX_CR4_MB1 32'h0000_0488
`define VCR_IDX_CR4_MAY1 32'h0000_0489
`define VCR_IDX_FIELD_LIM 32'h0000_048a
`define VCR_IDX_TRANS_CAP 32'h0000_048c
`define VCR_IDX_GFUNC 32'h0000_0491

// ****************************************
// field-encoding layout
// ****************************************
`define VCR_ENC_RSVD_HI 31
`define VCR_ENC_RSVD_LO 15
`define VCR_ENC_WID_HI 14
`define VCR_ENC_WID_LO 13
`define VCR_ENC_RSVD12 12
`define VCR_ENC_TYPE_HI 11
`define VCR_ENC_TYPE_LO 10
`define VCR_ENC_IDX_HI 9
`define VCR_ENC_IDX_LO 1
`define VCR_ENC_ACC 0
`define VCR_WID_16 2'h0
`define VCR_TYPE_CTRL 2'h0
`define VCR_IDX_TAG 9'h000
`define VCR_IDX_NOTIFY 9'h001
`define VCR_IDX_LISTIDX 9'h002

// ****************************************
// capability bit positions and masks
// ****************************************
`define VCR_CAP_EXEC_ONLY 0
`define VCR_CAP_WALK4 6
`define VCR_CAP_UC 8
`define VCR_CAP_WB 14
`define VCR_CAP_2M 16
`define VCR_CAP_1G 17
`define VCR_CAP_TINV 20
`define VCR_CAP_AD 21
`define VCR_CAP_ADVEXIT 22
`define VCR_CAP_TINV_SINGLE 25
`define VCR_CAP_TINV_ALL 26
`define VCR_CAP_GINV 32
`define VCR_CAP_GINV_ADDR 40
`define VCR_CAP_GINV_SINGLE 41
`define VCR_CAP_GINV_ALL 42
`define VCR_CAP_GINV_KEEPG 43
`define VCR_TRANS_CAP_MASK 64'h0000_0f01_0673_4141
`define VCR_FIELD_LIM_MASK 64'h0000_0000_0000_03fe
`define VCR_TE_EXEC_BIT 2
`define VCR_TE_UFETCH_BIT 10

`endif

//--- rtl/vcr_field_decode.v
// decoder for 32-bit structure field encodings, 16-bit control group
// assumes a one-cycle request pulse from logic on the same clock
`include "vcr_defines.vh"
`default_nettype none

module vcr_field_decode (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // request
    input wire encReq,
    input wire [31:0] enc,
    // which optional fields exist
    input wire supTag,
    input wire supNotify,
    input wire supListIdx,
    // answer
    output reg decDone_q,
    output reg decValid_q,
    output reg [2:0] decSel_q
);

    reg [2:0] sel;
    reg ok;

    // layout check, then index lookup gated by existence
    always @* begin
        sel = 3'h0;
        ok = 1'b0;
        if (enc[`VCR_ENC_RSVD_HI:`VCR_ENC_RSVD_LO] == 17'h00000 && !enc[`VCR_ENC_RSVD12]
            && enc[`VCR_ENC_WID_HI:`VCR_ENC_WID_LO] == `VCR_WID_16
            && !enc[`VCR_ENC_ACC]
            && enc[`VCR_ENC_TYPE_HI:`VCR_ENC_TYPE_LO] == `VCR_TYPE_CTRL) begin
            if (enc[`VCR_ENC_IDX_HI:`VCR_ENC_IDX_LO] == `VCR_IDX_TAG) begin
                sel = 3'h1;
                ok = supTag;
            end else if (enc[`VCR_ENC_IDX_HI:`VCR_ENC_IDX_LO] == `VCR_IDX_NOTIFY) begin
                sel = 3'h2;
                ok = supNotify;
            end else if (enc[`VCR_ENC_IDX_HI:`VCR_ENC_IDX_LO] == `VCR_IDX_LISTIDX) begin
                sel = 3'h4;
                ok = supListIdx;
            end
        end
    end

    // answer one cycle after the request
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            decDone_q <= 1'b0;
            decValid_q <= 1'b0;
            decSel_q <= 3'h0;
        end else begin
            decDone_q <= encReq;
            if (encReq) begin
                decValid_q <= ok;
                decSel_q <= ok ? sel : 3'h0;
            end
        end
    end

endmodule // vcr_field_decode

`default_nettype wire

//--- rtl/vcr_capability_bank.v
// read-only capability register bank for hardware virtualization support
// assumes requests come from core logic on the same clock as one-cycle pulses
`include "vcr_defines.vh"
`default_nettype none

module vcr_capability_bank #(
    // fixed-bit masks, implementation values
    parameter [63:0] CR0_MB1 = 64'h0000_0000_0000_0021,
    parameter [63:0] CR0_MAY1 = 64'h0000_0000_ffff_ffff,
    parameter [63:0] CR4_MB1 = 64'h0000_0000_0000_2000,
    parameter [63:0] CR4_MAY1 = 64'h0000_0000_003f_ffff,
    // highest field index in use
    parameter [8:0] FIELD_INDEX_MAX = 9'h017,
    // allowed guest-function controls
    parameter [63:0] GFUNC_ALLOWED = 64'h0000_0000_0000_0001,
    // control support that decides register and field existence
    parameter PRI_ACT_SEC = 1'b1,
    parameter SEC_TRANS = 1'b1,
    parameter SEC_TAG = 1'b1,
    parameter SEC_GFUNC = 1'b1,
    parameter SEC_POSTED = 1'b1,
    parameter SEC_VE = 1'b1,
    // translation and tag features
    parameter HAS_EXEC_ONLY = 1'b1,
    parameter HAS_WALK4 = 1'b1,
    parameter HAS_UC = 1'b1,
    parameter HAS_WB = 1'b1,
    parameter HAS_2M = 1'b1,
    parameter HAS_1G = 1'b0,
    parameter HAS_TINV = 1'b1,
    parameter HAS_TINV_SINGLE = 1'b1,
    parameter HAS_TINV_ALL = 1'b1,
    parameter HAS_AD = 1'b1,
    parameter HAS_ADVEXIT = 1'b1,
    parameter HAS_GINV = 1'b1,
    parameter HAS_GINV_ADDR = 1'b1,
    parameter HAS_GINV_SINGLE = 1'b1,
    parameter HAS_GINV_ALL = 1'b1,
    parameter HAS_GINV_KEEPG = 1'b1
) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // register read
    input wire rdReq,
    input wire [31:0] rdIndex,
    output reg rdDone_q,
    output reg rdFault_q,
    output reg [63:0] rdData_q,
    // register write attempt
    input wire wrReq,
    input wire [31:0] wrIndex,
    output reg wrDone_q,
    output reg wrFault_q,
    // control-register value adjustment
    input wire crReq,
    input wire crSelFour,
    input wire [63:0] crValue,
    input wire virtActive,
    output reg crDone_q,
    output reg [63:0] crOut_q,
    output reg crAdjusted_q,
    // guest entry check of guest-function controls
    input wire entryReq,
    input wire [63:0] gfuncCtrl,
    input wire actSecondary,
    input wire enableFunctions,
    output reg entryDone_q,
    output reg entryFail_q,
    // translation entry permission check
    input wire teReq,
    input wire [10:0] teBits,
    input wire modeBasedExec,
    output reg teDone_q,
    output reg teAccept_q,
    // violation exit information
    input wire violEvent,
    output reg advExitInfo_q,
    // field encoding decode
    input wire encReq,
    input wire [31:0] enc,
    output wire decDone_q,
    output wire decValid_q,
    output wire [2:0] decSel_q
);

    // ****************************************
    // helpers
    // ****************************************

    // apply a must/may pair to a proposed value
    function [63:0] forceBits;
        input [63:0] val;
        input [63:0] mb1;
        input [63:0] may1;
        begin
            forceBits = (val | mb1) & may1;
        end
    endfunction

    // match against a register index
    function isIdx;
        input [31:0] idx;
        input [31:0] refIdx;
        begin
            isIdx = (idx == refIdx);
        end
    endfunction

    // ****************************************
    // constant register contents
    // ****************************************

    // a must-be-one bit outside may-be-one would be contradictory, so clip it
    wire [63:0] cr0Mb1 = CR0_MB1 & CR0_MAY1;
    wire [63:0] cr4Mb1 = CR4_MB1 & CR4_MAY1;
    wire [63:0] cr0May1 = CR0_MAY1;
    wire [63:0] cr4May1 = CR4_MAY1;

    // index sits one place up, bit 0 and upper bits read zero
    wire [63:0] fieldLim = {54'h0, FIELD_INDEX_MAX, 1'b0} & `VCR_FIELD_LIM_MASK;

    // assemble feature bits one by one
    reg [63:0] transRaw;
    always @* begin
        transRaw = 64'h0;
        transRaw[`VCR_CAP_EXEC_ONLY] = HAS_EXEC_ONLY;
        transRaw[`VCR_CAP_WALK4] = HAS_WALK4;
        transRaw[`VCR_CAP_UC] = HAS_UC;
        transRaw[`VCR_CAP_WB] = HAS_WB;
        transRaw[`VCR_CAP_2M] = HAS_2M;
        transRaw[`VCR_CAP_1G] = HAS_1G;
        transRaw[`VCR_CAP_TINV] = HAS_TINV;
        transRaw[`VCR_CAP_TINV_SINGLE] = HAS_TINV_SINGLE;
        transRaw[`VCR_CAP_TINV_ALL] = HAS_TINV_ALL;
        transRaw[`VCR_CAP_AD] = HAS_AD;
        transRaw[`VCR_CAP_ADVEXIT] = HAS_ADVEXIT;
        transRaw[`VCR_CAP_GINV] = HAS_GINV;
        transRaw[`VCR_CAP_GINV_ADDR] = HAS_GINV_ADDR;
        transRaw[`VCR_CAP_GINV_SINGLE] = HAS_GINV_SINGLE;
        transRaw[`VCR_CAP_GINV_ALL] = HAS_GINV_ALL;
        transRaw[`VCR_CAP_GINV_KEEPG] = HAS_GINV_KEEPG;
    end

    // reserved positions forced low whatever the parameters say
    wire [63:0] transCap = transRaw & `VCR_TRANS_CAP_MASK;

    // existence of the optional registers
    wire transExists = PRI_ACT_SEC & (SEC_TRANS | SEC_TAG);
    wire gfuncExists = PRI_ACT_SEC & SEC_GFUNC;
    // an absent register allows nothing
    wire [63:0] gfuncCap = gfuncExists ? GFUNC_ALLOWED : 64'h0;

    // ****************************************
    // register read and write
    // ****************************************

    reg [63:0] rdData_d;
    reg rdFault_d;

    // index decode; absent and unknown indices fault with zero data
    always @* begin
        rdData_d = 64'h0;
        rdFault_d = 1'b0;
        if (isIdx(rdIndex, `VCR_IDX_CR0_MB1)) begin
            rdData_d = cr0Mb1;
        end else if (isIdx(rdIndex, `VCR_IDX_CR0_MAY1)) begin
            rdData_d = cr0May1;
        end else if (isIdx(rdIndex, `VCR_IDX_CR4_MB1)) begin
            rdData_d = cr4Mb1;
        end else if (isIdx(rdIndex, `VCR_IDX_CR4_MAY1)) begin
            rdData_d = cr4May1;
        end else if (isIdx(rdIndex, `VCR_IDX_FIELD_LIM)) begin
            rdData_d = fieldLim;
        end else if (isIdx(rdIndex, `VCR_IDX_TRANS_CAP) && transExists) begin
            rdData_d = transCap;
        end else if (isIdx(rdIndex, `VCR_IDX_GFUNC) && gfuncExists) begin
            rdData_d = gfuncCap;
        end else begin
            rdFault_d = 1'b1;
        end
    end

    // read answer one cycle after the request, data held until next read
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdDone_q <= 1'b0;
            rdFault_q <= 1'b0;
            rdData_q <= 64'h0;
        end else begin
            rdDone_q <= rdReq;
            if (rdReq) begin
                rdFault_q <= rdFault_d;
                rdData_q <= rdData_d;
            end
        end
    end

    // every write is refused; contents are constants and never change
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrDone_q <= 1'b0;
            wrFault_q <= 1'b0;
        end else begin
            wrDone_q <= wrReq;
            wrFault_q <= wrReq;
        end
    end

    // ****************************************
    // control-register adjustment
    // ****************************************

    reg [63:0] crNew;

    // masks only bite while virtualization is active
    always @* begin
        crNew = crValue;
        if (virtActive) begin
            if (crSelFour) begin
                crNew = forceBits(crValue, cr4Mb1, cr4May1);
            end else begin
                crNew = forceBits(crValue, cr0Mb1, cr0May1);
            end
        end
    end

    // adjusted value and a flag when any bit was overridden
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            crDone_q <= 1'b0;
            crOut_q <= 64'h0;
            crAdjusted_q <= 1'b0;
        end else begin
            crDone_q <= crReq;
            if (crReq) begin
                crOut_q <= crNew;
                crAdjusted_q <= (crNew != crValue);
            end
        end
    end

    // ****************************************
    // guest entry check
    // ****************************************

    // only checked when both gating controls are set
    wire gfuncBad = |(gfuncCtrl & ~gfuncCap);
    wire entryBad = actSecondary & enableFunctions & gfuncBad;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            entryDone_q <= 1'b0;
            entryFail_q <= 1'b0;
        end else begin
            entryDone_q <= entryReq;
            if (entryReq) begin
                entryFail_q <= entryBad;
            end
        end
    end

    // ****************************************
    // translation entry permission check
    // ****************************************

    reg teOk;

    // entries with read and write clear need a supported fetch form
    always @(*) begin
        teOk = 1'b1;
        if (teBits[1:0] == 2'h0) begin
            teOk = 1'b0;
            if (transCap[`VCR_CAP_EXEC_ONLY] && teBits[`VCR_TE_EXEC_BIT]) begin
                teOk = 1'b1;
            end else if (transCap[`VCR_CAP_EXEC_ONLY] && modeBasedExec
                         && teBits[`VCR_TE_UFETCH_BIT]) begin
                teOk = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            teDone_q <= 1'b0;
            teAccept_q <= 1'b0;
        end else begin
            teDone_q <= teReq;
            if (teReq) begin
                teAccept_q <= teOk;
            end
        end
    end

    // ****************************************
    // violation exit information
    // ****************************************

    // advanced detail only when the capability bit reads 1
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            advExitInfo_q <= 1'b0;
        end else begin
            advExitInfo_q <= violEvent & transCap[`VCR_CAP_ADVEXIT];
        end
    end

    // ****************************************
    // field encoding decode
    // ****************************************

    // each optional field follows its enabling control
    vcr_field_decode u_decode (
        .clk(clk),
        .arst_n(arst_n),
        .encReq(encReq),
        .enc(enc),
        .supTag(PRI_ACT_SEC & SEC_TAG),
        .supNotify(SEC_POSTED),
        .supListIdx(PRI_ACT_SEC & SEC_VE),
        .decDone_q(decDone_q),
        .decValid_q(decValid_q),
        .decSel_q(decSel_q)
    );

endmodule // vcr_capability_bank

`default_nettype wire

//--- verif/vcr_capability_bank_sva.sv
// checker for the capability register bank, watching its top-level ports
// assumes the bank keeps its default mask and capability parameters
`default_nettype none

module vcr_capability_bank_sva #(
    parameter logic [63:0] CR0_MB1 = 64'h0000_0000_0000_0021,
    parameter logic [63:0] CR0_MAY1 = 64'h0000_0000_ffff_ffff,
    parameter logic [63:0] CR4_MB1 = 64'h0000_0000_0000_2000,
    parameter logic [63:0] CR4_MAY1 = 64'h0000_0000_003f_ffff,
    parameter logic [63:0] GFUNC_ALLOWED = 64'h0000_0000_0000_0001
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register access
    input wire logic rdReq,
    input wire logic [31:0] rdIndex,
    input wire logic rdFault_q,
    input wire logic rdDone_q,
    input wire logic [63:0] rdData_q,
    input wire logic wrReq,
    input wire logic wrDone_q,
    input wire logic wrFault_q,
    // control-register adjustment
    input wire logic crReq,
    input wire logic crSelFour,
    input wire logic virtActive,
    input wire logic [63:0] crOut_q,
    // entry and translation checks
    input wire logic entryReq,
    input wire logic [63:0] gfuncCtrl,
    input wire logic actSecondary,
    input wire logic enableFunctions,
    input wire logic entryFail_q,
    input wire logic teReq,
    input wire logic [10:0] teBits,
    input wire logic modeBasedExec,
    input wire logic teAccept_q,
    input wire logic violEvent,
    input wire logic advExitInfo_q,
    // field decode
    input wire logic encReq,
    input wire logic [31:0] enc,
    input wire logic decValid_q,
    input wire logic [2:0] decSel_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // features all present except the 1-Gbyte mapping
    localparam logic [63:0] TCAP = 64'h0000_0f01_0671_4141;

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    rd_answer_a: assert property (rdReq |=> rdDone_q)
        else $error("read not answered");
    lim_value_a: assert property (rdReq && rdIndex == 32'h0000_048a |=> rdData_q == 64'h0000_0000_0000_002e)
        else $error("index limit wrong");
    cap_value_a: assert property (rdReq && rdIndex == 32'h0000_048c |=> rdData_q == TCAP)
        else $error("capability word wrong");
    unmapped_fault_a: assert property (rdReq && rdIndex[31:8] != 24'h00_0004 |=> rdFault_q && rdData_q == 64'h0)
        else $error("unmapped read not faulted");
    write_refused_a: assert property (wrReq |=> wrDone_q && wrFault_q)
        else $error("write not refused");
    cr0_one_a: assert property (crReq && virtActive && !crSelFour |=> (crOut_q & CR0_MB1) == CR0_MB1)
        else $error("cr0 one bit lost");
    cr0_zero_a: assert property (crReq && virtActive && !crSelFour |=> (crOut_q & ~CR0_MAY1) == 64'h0)
        else $error("cr0 zero bit set");
    cr4_fixed_a: assert property (crReq && virtActive && crSelFour |=>
        (crOut_q & CR4_MB1) == CR4_MB1 && (crOut_q & ~CR4_MAY1) == 64'h0)
        else $error("cr4 fixed bit wrong");
    entry_fail_a: assert property (entryReq |=>
        entryFail_q == $past(actSecondary && enableFunctions && |(gfuncCtrl & ~GFUNC_ALLOWED)))
        else $error("entry verdict wrong");
    exec_only_a: assert property (teReq && teBits[2:0] == 3'h4 |=> teAccept_q)
        else $error("execute-only refused");
    fetch_only_a: assert property (teReq && teBits[2:0] == 3'h0 |=> teAccept_q == $past(modeBasedExec && teBits[10]))
        else $error("fetch-only verdict wrong");
    adv_exit_a: assert property (violEvent |=> advExitInfo_q ##1 !advExitInfo_q || $past(violEvent))
        else $error("exit information wrong");
    dec_notify_a: assert property (encReq && enc == 32'h0000_0002 |=> decValid_q && decSel_q == 3'h2)
        else $error("notify field not decoded");
    dec_access_a: assert property (encReq && enc[0] |=> !decValid_q && decSel_q == 3'h0)
        else $error("odd encoding accepted");
endmodule // vcr_capability_bank_sva

bind vcr_capability_bank vcr_capability_bank_sva u_sva (.*);

`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the capability register bank
// assumes the bank's default parameters, one clock, inputs driven at falling edges
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] MB0 = 64'h21;
    localparam logic [63:0] MAY0 = 64'hffff_ffff;
    localparam logic [63:0] MB4 = 64'h2000;
    localparam logic [63:0] MAY4 = 64'h3f_ffff;
    logic clk, arst_n, rdReq, wrReq, crReq, crSelFour, virtActive, entryReq, actSecondary;
    logic enableFunctions, teReq, modeBasedExec, violEvent, encReq;
    logic rdDone_q, rdFault_q, wrDone_q, wrFault_q, crDone_q, crAdjusted_q, entryDone_q;
    logic entryFail_q, teDone_q, teAccept_q, advExitInfo_q, decDone_q, decValid_q;
    logic [2:0] decSel_q;
    logic [10:0] teBits;
    logic [31:0] rdIndex, wrIndex, enc, r;
    logic [31:0] seed = 32'd53914;
    logic [63:0] rdData_q, crOut_q, crValue, gfuncCtrl, v, e;
    int nErrors = 0;
    int nTests = 0;

    vcr_capability_bank u_vcr_capability_bank (.clk(clk), .arst_n(arst_n), .rdReq(rdReq), .rdIndex(rdIndex),
        .rdDone_q(rdDone_q), .rdFault_q(rdFault_q), .rdData_q(rdData_q), .wrReq(wrReq), .wrIndex(wrIndex),
        .wrDone_q(wrDone_q), .wrFault_q(wrFault_q), .crReq(crReq), .crSelFour(crSelFour), .crValue(crValue),
        .virtActive(virtActive), .crDone_q(crDone_q), .crOut_q(crOut_q), .crAdjusted_q(crAdjusted_q),
        .entryReq(entryReq), .gfuncCtrl(gfuncCtrl), .actSecondary(actSecondary),
        .enableFunctions(enableFunctions), .entryDone_q(entryDone_q), .entryFail_q(entryFail_q),
        .teReq(teReq), .teBits(teBits), .modeBasedExec(modeBasedExec), .teDone_q(teDone_q),
        .teAccept_q(teAccept_q), .violEvent(violEvent), .advExitInfo_q(advExitInfo_q), .encReq(encReq),
        .enc(enc), .decDone_q(decDone_q), .decValid_q(decValid_q), .decSel_q(decSel_q));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // fault flag above the expected word
    function automatic logic [64:0] regExp(input logic [31:0] i);
        case (i)
            32'h486: regExp = {1'b0, MB0};
            32'h487: regExp = {1'b0, MAY0};
            32'h488: regExp = {1'b0, MB4};
            32'h489: regExp = {1'b0, MAY4};
            32'h48a: regExp = {1'b0, 64'h2e};
            32'h48c: regExp = {1'b0, 64'h0000_0f01_0671_4141};
            32'h491: regExp = {1'b0, 64'h1};
            default: regExp = {1'b1, 64'h0};
        endcase
    endfunction

    // wide enough for a flag pair above a full 64-bit word
    task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string what);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one request per call; the idle cycle after it keeps drivers single per step
    task automatic rd(input logic [31:0] i);
        @(negedge clk);
        rdReq = 1'b1;
        rdIndex = i;
        @(negedge clk);
        rdReq = 1'b0;
        chk({rdDone_q, rdFault_q, rdData_q}, {1'b1, regExp(i)}, "read");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // clock, watchdog, sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // the sequence needs about 9000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        nErrors++;
        results();
    end

    initial begin
        {rdReq, wrReq, crReq, crSelFour, virtActive, entryReq, actSecondary} = '0;
        {enableFunctions, teReq, modeBasedExec, violEvent, encReq} = '0;
        {rdIndex, wrIndex, enc, teBits, crValue, gfuncCtrl} = '0;
        arst_n = 1'b0;
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk({rdDone_q, rdFault_q, rdData_q}, '0, "reset read");
        chk({crDone_q, crAdjusted_q, crOut_q}, '0, "reset adjust");
        for (int i = 32'h484; i < 32'h494; i++) rd(i);
        rd(xs());
        for (int i = 32'h484; i < 32'h494; i++) begin
            @(negedge clk);
            wrReq = 1'b1;
            wrIndex = i;
            @(negedge clk);
            wrReq = 1'b0;
            chk({wrDone_q, wrFault_q}, 2'h3, "write");
            rd(i);
        end
        $display("test registers finished");
        for (int j = 0; j < 66; j++) begin
            r = xs();
            v = (j == 0) ? '0 : (j == 1) ? '1 : {xs(), r};
            @(negedge clk);
            {crReq, crSelFour, virtActive, crValue} = {1'b1, r[3:2], v};
            @(negedge clk);
            crReq = 1'b0;
            e = r[2] ? (v | (r[3] ? MB4 : MB0)) & (r[3] ? MAY4 : MAY0) : v;
            chk({crDone_q, crAdjusted_q, crOut_q}, {1'b1, e != v, e}, "adjust");
            @(negedge clk);
            {entryReq, actSecondary, enableFunctions} = {1'b1, r[5:4]};
            gfuncCtrl = r[6] ? {63'h0, r[7]} : v;
            @(negedge clk);
            entryReq = 1'b0;
            chk({entryDone_q, entryFail_q}, {1'b1, &r[5:4] && |(gfuncCtrl & ~64'h1)}, "entry");
        end
        $display("test adjust and entry finished");
        for (int k = 0; k < 4096; k++) begin
            @(negedge clk);
            teReq = 1'b1;
            {modeBasedExec, teBits} = k[11:0];
            @(negedge clk);
            teReq = 1'b0;
            chk({teDone_q, teAccept_q}, {1'b1, |k[2:0] || &k[11:10]}, "translation");
        end
        $display("test translation finished");
        for (int j = 0; j < 48; j++) begin
            r = (j < 8) ? j : (j < 12) ? 32'h1 << (9 + j) : xs() & 32'h0001_f407;
            @(negedge clk);
            encReq = 1'b1;
            enc = r;
            @(negedge clk);
            encReq = 1'b0;
            e = (r & 32'hffff_fc01) == 0 && r[9:1] < 3 ? {60'h1, 3'h1 << r[9:1]} : '0;
            chk({decDone_q, decValid_q, decSel_q}, {1'b1, e[3:0]}, "decode");
        end
        @(negedge clk);
        violEvent = 1'b1;
        @(negedge clk);
        violEvent = 1'b0;
        chk(advExitInfo_q, 1'b1, "exit info");
        @(negedge clk);
        chk(advExitInfo_q, 1'b0, "exit info end");
        $display("test decode and exit finished");
        results();
    end
endmodule // tb_top

`default_nettype wire
